// ===== design/bit_toggle_branch_call_exec.sv
// Four-phase executor for bit toggle, two branches and the call
`timescale 1ns/1ps
`default_nettype none
module bit_toggle_branch_call_exec (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic [20:0] prog_addr_out,
  input wire logic [15:0] prog_data_in,
  output logic [11:0] data_addr_out,
  output logic data_rd_out,
  input wire logic [7:0] data_rdata_in,
  output logic data_wr_out,
  output logic [7:0] data_wdata_out,
  output logic stack_push_out,
  output logic [20:0] return_stack_top_out
);
  exec_pkg::phase_e phase;
  logic second;
  logic [15:0] instr;
  logic [20:0] program_counter;
  logic [7:0] call_low;
  logic ext_en;
  logic [7:0] working;
  logic [4:0] status;
  logic [3:0] bank_select_reg;
  logic [11:0] index_base;
  logic [7:0] working_shadow;
  logic [4:0] status_shadow;
  logic [3:0] bank_select_shadow;
  logic [20:0] return_stack_top;

  logic q1, q2, q3, q4, act;
  logic op_toggle, op_ovf, op_zero, op_call, taken;
  logic [7:0] toggle_mask;
  logic [11:0] next_data_addr;
  logic [20:0] branch_dest, call_dest, push_value;
  logic wr_ctrl, wr_work, wr_status, wr_bank, wr_idx, wr_pc;
  logic [31:0] read_mux;

  assign q1 = phase == exec_pkg::Q1;
  assign q2 = phase == exec_pkg::Q2;
  assign q3 = phase == exec_pkg::Q3;
  assign q4 = phase == exec_pkg::Q4;
  // The dead second cycle of a jump or call decodes nothing
  assign act = !second;
  assign op_toggle = act && exec_pkg::is_toggle(instr);
  assign op_ovf = act && exec_pkg::is_ovf_br(instr);
  assign op_zero = act && exec_pkg::is_zero_br(instr);
  assign op_call = act && exec_pkg::is_call(instr);
  assign taken = (op_ovf && status[exec_pkg::ST_OV])
                 || (op_zero && status[exec_pkg::ST_Z]);
  assign toggle_mask = 8'(8'h01 << instr[exec_pkg::BIT_LSB +: 3]);
  assign branch_dest = exec_pkg::br_target(program_counter,
                                           instr[7:0]);
  assign call_dest = {prog_data_in[11:0], call_low, 1'b0};
  // Counter already points past the first word, so step back before adding
  assign push_value = 21'(program_counter - exec_pkg::PC_INC
                          + exec_pkg::RET_OFS);

  // Operand address is taken straight off the fetched word
  data_addr_resolve u_resolve (
    .file_in(prog_data_in[7:0]),
    .access_sel_in(prog_data_in[exec_pkg::ACC_BIT]),
    .bank_in(bank_select_reg),
    .ext_en_in(ext_en),
    .index_base_in(index_base),
    .addr_out(next_data_addr)
  );

  assign data_rd_out = q2 && op_toggle;
  assign data_wr_out = q4 && op_toggle;
  assign stack_push_out = q3 && op_call;
  assign prog_addr_out = program_counter;
  assign return_stack_top_out = return_stack_top;

  assign wr_ctrl = reg_wr_in && reg_addr_in == exec_pkg::R_CTRL;
  assign wr_work = reg_wr_in && reg_addr_in == exec_pkg::R_WORK;
  assign wr_status = reg_wr_in && reg_addr_in == exec_pkg::R_STATUS;
  assign wr_bank = reg_wr_in && reg_addr_in == exec_pkg::R_BANK;
  assign wr_idx = reg_wr_in && reg_addr_in == exec_pkg::R_IDXBASE;
  assign wr_pc = reg_wr_in && reg_addr_in == exec_pkg::R_PC;

  assign read_mux =
    reg_addr_in == exec_pkg::R_CTRL ? {31'h0, ext_en}
    : reg_addr_in == exec_pkg::R_WORK ? {24'h0, working}
    : reg_addr_in == exec_pkg::R_STATUS ? {27'h0, status}
    : reg_addr_in == exec_pkg::R_BANK ? {28'h0, bank_select_reg}
    : reg_addr_in == exec_pkg::R_IDXBASE ? {20'h0, index_base}
    : reg_addr_in == exec_pkg::R_PC ? {11'h0, program_counter}
    : reg_addr_in == exec_pkg::R_WSHAD ? {24'h0, working_shadow}
    : reg_addr_in == exec_pkg::R_SSHAD ? {27'h0, status_shadow}
    : reg_addr_in == exec_pkg::R_BSHAD ? {28'h0, bank_select_shadow}
    : reg_addr_in == exec_pkg::R_TOS ? {11'h0, return_stack_top}
    : reg_addr_in == exec_pkg::R_STATE ? {27'h0, second, phase}
    : 32'h0;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0;
    end else begin
      reg_rdata_out <= reg_rd_in ? read_mux : 32'h0;
    end
  end

  // Phase ring
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phase <= exec_pkg::Q1;
    end else begin
      unique case (phase)
        exec_pkg::Q1: phase <= exec_pkg::Q2;
        exec_pkg::Q2: phase <= exec_pkg::Q3;
        exec_pkg::Q3: phase <= exec_pkg::Q4;
        exec_pkg::Q4: phase <= exec_pkg::Q1;
        default: phase <= exec_pkg::Q1;
      endcase
    end
  end

  // Second cycle follows a taken branch or a call
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      second <= 1'b0;
    end else if (q4) begin
      second <= taken || op_call;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      instr <= 16'h0000;
      data_addr_out <= 12'h000;
    end else if (q1 && act) begin
      instr <= prog_data_in;
      data_addr_out <= next_data_addr;
    end
  end

  // Core updates beat a software write in the same cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      program_counter <= exec_pkg::PC_RST;
    end else if (q1 && act) begin
      program_counter <= program_counter + exec_pkg::PC_INC;
    end else if (q4 && taken) begin
      program_counter <= branch_dest;
    end else if (q4 && op_call) begin
      program_counter <= call_dest;
    end else if (wr_pc) begin
      program_counter <= reg_wdata_in[20:0];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      data_wdata_out <= 8'h00;
    end else if (q3 && op_toggle) begin
      data_wdata_out <= data_rdata_in ^ toggle_mask;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      call_low <= 8'h00;
      return_stack_top <= exec_pkg::PC_RST;
    end else if (q2 && op_call) begin
      call_low <= instr[7:0];
      return_stack_top <= push_value;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      working_shadow <= exec_pkg::BYTE_RST;
      status_shadow <= exec_pkg::STATUS_RST;
      bank_select_shadow <= 4'h0;
    end else if (q3 && op_call && instr[exec_pkg::SHADOW_BIT]) begin
      working_shadow <= working;
      status_shadow <= status;
      bank_select_shadow <= bank_select_reg;
    end
  end

  // Status only moves under software, never from these instructions
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      status <= exec_pkg::STATUS_RST;
    end else if (wr_status) begin
      status <= reg_wdata_in[4:0];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_en <= 1'b0;
      working <= exec_pkg::BYTE_RST;
      bank_select_reg <= 4'h0;
      index_base <= exec_pkg::IDX_RST;
    end else begin
      if (wr_ctrl) ext_en <= reg_wdata_in[exec_pkg::CTRL_EXT];
      if (wr_work) working <= reg_wdata_in[7:0];
      if (wr_bank) bank_select_reg <= reg_wdata_in[3:0];
      if (wr_idx) index_base <= reg_wdata_in[11:0];
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_dead_cycle;
    second [*4] ##1 !second;
  endsequence

  property p_toggle;
    q4 && op_toggle |-> data_wdata_out ==
      ($past(data_rdata_in) ^ toggle_mask) && data_wr_out;
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle data wrong");

  property p_indexed;
    q2 && op_toggle && !instr[exec_pkg::ACC_BIT] && ext_en
      && instr[7:0] <= exec_pkg::INDEX_LIMIT && $stable(index_base)
      |-> data_addr_out == 12'(index_base + {4'h0, instr[7:0]});
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed address wrong");

  property p_ovf_skip;
    q4 && op_ovf && !status[exec_pkg::ST_OV] |=> !second
      && program_counter == $past(program_counter);
  endproperty
  a_ovf_skip: assert property (p_ovf_skip)
    else $error("overflow branch taken wrongly");

  property p_zero_jump;
    q4 && op_zero && status[exec_pkg::ST_Z] |=> second;
  endproperty
  a_zero_jump: assert property (p_zero_jump)
    else $error("zero branch not taken");

  property p_target;
    q4 && taken |=> program_counter ==
      exec_pkg::br_target($past(program_counter), $past(instr[7:0]));
  endproperty
  a_target: assert property (p_target)
    else $error("branch target wrong");

  property p_branch_time;
    q4 && taken |=> s_dead_cycle;
  endproperty
  a_branch_time: assert property (p_branch_time)
    else $error("taken branch not two cycles");

  property p_call_load;
    q4 && op_call |=> program_counter ==
      {$past(prog_data_in[11:0]), call_low, 1'b0};
  endproperty
  a_call_load: assert property (p_call_load)
    else $error("call target wrong");

  property p_push;
    stack_push_out |-> return_stack_top_out ==
      21'(program_counter + exec_pkg::PC_INC);
  endproperty
  a_push: assert property (p_push)
    else $error("return address wrong");

  property p_shadow;
    q3 && op_call |=> instr[exec_pkg::SHADOW_BIT]
      ? working_shadow == $past(working)
        && status_shadow == $past(status)
        && bank_select_shadow == $past(bank_select_reg)
      : $stable(working_shadow) && $stable(status_shadow)
        && $stable(bank_select_shadow);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("shadow copy wrong");

  property p_call_time;
    q4 && op_call |=> s_dead_cycle;
  endproperty
  a_call_time: assert property (p_call_time)
    else $error("call not two cycles");

  property p_banked;
    q2 && op_toggle && instr[exec_pkg::ACC_BIT] && $stable(bank_select_reg)
      |-> data_addr_out == {bank_select_reg, instr[7:0]};
  endproperty
  a_banked: assert property (p_banked)
    else $error("banked address wrong");

  property p_status_kept;
    !wr_status |=> $stable(status);
  endproperty
  a_status_kept: assert property (p_status_kept)
    else $error("status changed by execution");
endmodule
`default_nettype wire

// ===== design/data_addr_resolve.sv
// Resolves a file operand into a data-memory address
`timescale 1ns/1ps
`default_nettype none
module data_addr_resolve (
  input wire logic [7:0] file_in,
  input wire logic access_sel_in,
  input wire logic [3:0] bank_in,
  input wire logic ext_en_in,
  input wire logic [11:0] index_base_in,
  output logic [11:0] addr_out
);
  logic indexed;
  logic low_access;
  logic [11:0] indexed_addr;
  logic [11:0] access_addr;

  assign low_access = file_in <= exec_pkg::INDEX_LIMIT;
  assign indexed = !access_sel_in && ext_en_in && low_access;
  assign indexed_addr = 12'(index_base_in + {4'h0, file_in});
  // Access bank: low part of bank 0 and top of the last bank
  assign access_addr = low_access ? {4'h0, file_in}
                       : {exec_pkg::ACCESS_HIGH_PAGE, file_in};
  assign addr_out = indexed ? indexed_addr
                    : access_sel_in ? {bank_in, file_in}
                    : access_addr;
endmodule
`default_nettype wire

// ===== design/exec_pkg.sv
// Constants, field layouts and decode helpers for the instruction executor
`default_nettype none
package exec_pkg;
  localparam int PC_W = 21;
  localparam int DAT_W = 8;
  localparam int DADR_W = 12;
  localparam int REG_AW = 4;
  localparam int REG_DW = 32;

  typedef enum logic [3:0] {
    Q1 = 4'b0001,
    Q2 = 4'b0010,
    Q3 = 4'b0100,
    Q4 = 4'b1000
  } phase_e;

  // Opcode fields
  localparam logic [3:0] TOGGLE_NIB = 4'h7;
  localparam logic [7:0] OVF_BR_OP = 8'he4;
  localparam logic [7:0] ZERO_BR_OP = 8'he0;
  localparam logic [6:0] CALL_OP = 7'h76;
  localparam int BIT_LSB = 9;
  localparam int ACC_BIT = 8;
  localparam int SHADOW_BIT = 8;
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hf;

  // Program counter steps in bytes
  localparam logic [PC_W-1:0] PC_INC = 21'h000002;
  localparam logic [PC_W-1:0] RET_OFS = 21'h000004;

  // Status bit positions
  localparam int ST_W = 5;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;

  // Register indices
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_WORK = 4'h1;
  localparam logic [3:0] R_STATUS = 4'h2;
  localparam logic [3:0] R_BANK = 4'h3;
  localparam logic [3:0] R_IDXBASE = 4'h4;
  localparam logic [3:0] R_PC = 4'h5;
  localparam logic [3:0] R_WSHAD = 4'h6;
  localparam logic [3:0] R_SSHAD = 4'h7;
  localparam logic [3:0] R_BSHAD = 4'h8;
  localparam logic [3:0] R_TOS = 4'h9;
  localparam logic [3:0] R_STATE = 4'ha;
  localparam int CTRL_EXT = 0;

  // Reset values
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [ST_W-1:0] STATUS_RST = 5'h00;
  localparam logic [DADR_W-1:0] IDX_RST = 12'h000;

  function automatic logic is_toggle(input logic [15:0] w);
    return w[15:12] == TOGGLE_NIB;
  endfunction

  function automatic logic is_ovf_br(input logic [15:0] w);
    return w[15:8] == OVF_BR_OP;
  endfunction

  function automatic logic is_zero_br(input logic [15:0] w);
    return w[15:8] == ZERO_BR_OP;
  endfunction

  function automatic logic is_call(input logic [15:0] w);
    return w[15:9] == CALL_OP;
  endfunction

  // Incremented counter plus twice the signed offset
  function automatic logic [PC_W-1:0] br_target(input logic [PC_W-1:0] pc,
                                                input logic [7:0] n);
    return pc + {{12{n[7]}}, n, 1'b0};
  endfunction
endpackage
`default_nettype wire

// ===== tb/bit_toggle_branch_call_exec_test.sv
// Self-checking bench for the instruction executor
`timescale 1ns/1ps
`default_nettype none
module bit_toggle_branch_call_exec_test;
  localparam int INS = 128;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [20:0] prog_addr_out, return_stack_top_out;
  logic [15:0] prog_data_in;
  logic [11:0] data_addr_out;
  logic data_rd_out, data_wr_out, stack_push_out;
  logic [7:0] data_rdata_in, data_wdata_out;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  bit_toggle_branch_call_exec bit_toggle_branch_call_exec_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .prog_addr_out(prog_addr_out), .prog_data_in(prog_data_in),
    .data_addr_out(data_addr_out), .data_rd_out(data_rd_out),
    .data_rdata_in(data_rdata_in), .data_wr_out(data_wr_out),
    .data_wdata_out(data_wdata_out), .stack_push_out(stack_push_out),
    .return_stack_top_out(return_stack_top_out));

  mem_partner mem_partner_i (
    .mclk_in(mclk_in), .prog_addr_in(prog_addr_out),
    .prog_data_out(prog_data_in), .data_addr_in(data_addr_out),
    .data_rd_in(data_rd_out), .data_rdata_out(data_rdata_in),
    .data_wr_in(data_wr_out), .data_wdata_in(data_wdata_out),
    .stack_push_in(stack_push_out), .stack_top_in(return_stack_top_out));

  always #2.5 mclk_in = ~mclk_in;

  task automatic summarize();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // About 20 runs of some 300 cycles each; far above that means a hang
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge mclk_in);
    #1;
  endtask

  task automatic reg_write(input logic [3:0] a, input int d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= 32'(d);
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic reg_check(input logic [3:0] a, input int exp);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1;
    check(reg_rdata_out, 32'(exp));
  endtask

  // Program sits after a run of no-ops so setup ends before it executes
  task automatic start(input logic [15:0] w0, input logic [15:0] w1);
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    // Core is held in reset here, so no push can race the clear
    for (int i = 0; i < 256; i++)
      mem_partner_i.pmem[i] = 16'h0000;
    mem_partner_i.pmem[INS / 2] = w0;
    mem_partner_i.pmem[INS / 2 + 1] = w1;
    mem_partner_i.stack.delete();
    rst_in <= 1'b0;
  endtask

  // Cycles from the counter passing the instruction to passing dest
  task automatic run_to(input int dest, input int exp_cyc);
    int n;
    for (n = 0; n < 400 && prog_addr_out !== 21'(INS + 2); n++)
      tick();
    for (n = 0; n < 40 && prog_addr_out !== 21'(dest + 2); n++)
      tick();
    check(32'(n), 32'(exp_cyc));
  endtask

  initial begin
    int f, b, a, x, bk, ix, v, ea, n, st, fl, op, k, s, wv, rnd, pos, oth;
    logic [15:0] w;
    rnd = $urandom(34);
    for (int t = 0; t < 8; t++) begin
      f = (t % 2) ? $urandom_range(255) : $urandom_range(95);
      b = $urandom_range(7);
      // Fixed pattern so indexed, access and banked paths are all reached
      a = (t / 2) % 2;
      x = (t / 4) % 2;
      bk = $urandom_range(15);
      ix = $urandom_range(4095);
      v = $urandom_range(255);
      st = $urandom_range(31);
      if (a)
        ea = bk * 256 + f;
      else if (x && f <= 95)
        ea = (ix + f) % 4096;
      else if (f <= 95)
        ea = f;
      else
        ea = 3840 + f;
      w = {exec_pkg::TOGGLE_NIB, 12'h000} | 16'(b * 512 + a * 256 + f);
      start(w, 16'h0000);
      mem_partner_i.dmem[ea] = 8'(v);
      reg_write(exec_pkg::R_CTRL, x);
      reg_write(exec_pkg::R_BANK, bk);
      reg_write(exec_pkg::R_IDXBASE, ix);
      reg_write(exec_pkg::R_STATUS, st);
      run_to(INS + 2, 4);
      v = v ^ (1 << b);
      check(32'(mem_partner_i.dmem[ea]), 32'(v));
      reg_check(exec_pkg::R_STATUS, st);
    end
    $display("Test toggle done");
    for (int t = 0; t < 8; t++) begin
      op = t % 2;
      fl = (t / 2) % 2;
      n = $urandom_range(187) - 60;
      if (n == -1)
        n = -2;
      pos = op ? exec_pkg::ST_OV : exec_pkg::ST_Z;
      oth = op ? exec_pkg::ST_Z : exec_pkg::ST_OV;
      st = $urandom_range(31);
      // Other flag set opposite, so testing the wrong flag shows
      if (fl)
        st = (st | (1 << pos)) & ~(1 << oth);
      else
        st = (st & ~(1 << pos)) | (1 << oth);
      w = {op ? exec_pkg::OVF_BR_OP : exec_pkg::ZERO_BR_OP, 8'(n)};
      start(w, 16'h0000);
      reg_write(exec_pkg::R_STATUS, st);
      run_to(INS + 2 + fl * 2 * n, fl ? 8 : 4);
      reg_check(exec_pkg::R_STATUS, st);
    end
    $display("Test branch done");
    for (int t = 0; t < 4; t++) begin
      s = t % 2;
      k = $urandom_range(1048575);
      // Keep the aliased target clear of the call's own words
      if ((k % 256) >= 63 && (k % 256) <= 65)
        k = k ^ 128;
      wv = $urandom_range(255);
      bk = $urandom_range(15);
      st = $urandom_range(31);
      w = {exec_pkg::CALL_OP, 1'(s), 8'(k)};
      start(w, {4'hf, 12'(k >> 8)});
      reg_write(exec_pkg::R_WORK, wv);
      reg_write(exec_pkg::R_BANK, bk);
      reg_write(exec_pkg::R_STATUS, st);
      run_to(k * 2, 8);
      check(32'(mem_partner_i.stack.size()), 32'h1);
      check(32'(mem_partner_i.stack[0]), 32'(INS + 4));
      reg_check(exec_pkg::R_TOS, INS + 4);
      reg_check(exec_pkg::R_WSHAD, s ? wv : 0);
      reg_check(exec_pkg::R_SSHAD, s ? st : 0);
      reg_check(exec_pkg::R_BSHAD, s ? bk : 0);
      reg_check(exec_pkg::R_STATUS, st);
    end
    $display("Test call done");
    summarize();
  end
endmodule
`default_nettype wire

// ===== tb/mem_partner.sv
// Program, data and return-stack model facing the executor
`timescale 1ns/1ps
`default_nettype none
module mem_partner (
  input wire logic mclk_in,
  input wire logic [20:0] prog_addr_in,
  output logic [15:0] prog_data_out,
  input wire logic [11:0] data_addr_in,
  input wire logic data_rd_in,
  output logic [7:0] data_rdata_out,
  input wire logic data_wr_in,
  input wire logic [7:0] data_wdata_in,
  input wire logic stack_push_in,
  input wire logic [20:0] stack_top_in
);
  logic [15:0] pmem [0:255];
  logic [7:0] dmem [0:4095];
  logic [20:0] stack [$];
  // Only the low word index decodes, so far call targets alias here
  assign prog_data_out = pmem[prog_addr_in[8:1]];
  logic [7:0] rd_byte = 8'h00;
  assign data_rdata_out = rd_byte;
  always @(posedge mclk_in) begin
    // Read byte holds one cycle, then scrambles so a late sample shows
    if (data_rd_in)
      rd_byte <= dmem[data_addr_in];
    else
      rd_byte <= ~rd_byte;
    if (data_wr_in)
      dmem[data_addr_in] <= data_wdata_in;
    if (stack_push_in)
      stack.push_back(stack_top_in);
  end
endmodule
`default_nettype wire
